// ### tdr_params.svh
// constants for the two-wire dac code receiver
`ifndef TDR_PARAMS_SVH
`define TDR_PARAMS_SVH
`define TDR_CLK_HZ 25000000
`define TDR_SCL_MAX_HZ 400000
`define TDR_ADDR_DEFAULT 7'h30
`define TDR_ADDR_BYTE_LO 8'h60
`define TDR_ADDR_BYTE_HI 8'h66
`define TDR_GEN_CALL 7'h00
`define TDR_TEN_BIT_PFX 5'h1e
`define TDR_CODE_RESET 8'h00
`define TDR_PD_ENTRY_US 5
`define TDR_PD_EXIT_US 50
`define TDR_PD_ENTRY_CYC ((`TDR_PD_ENTRY_US * (`TDR_CLK_HZ / 1000000)))
`define TDR_PD_EXIT_CYC ((`TDR_PD_EXIT_US * (`TDR_CLK_HZ / 1000000)))
`define TDR_BITS_PER_BYTE 4'h8
`endif

// ### tdr_pkg.sv
// types shared by the two-wire dac code receiver
package tdr_pkg;
    typedef enum logic [2:0] {
        TDR_IDLE, TDR_ADDR, TDR_ADDR_ACK, TDR_DATA, TDR_DATA_ACK, TDR_WAIT_STOP
    } tdr_state_t;
    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
        logic sda;
    } tdr_line_ev_t;
    typedef struct packed {
        logic power_down_bit;
        logic [7:0] code;
    } tdr_update_t;
endpackage : tdr_pkg

// ### tdr_line_sync.sv
// synchronises scl and sda and finds edges, start and stop
`timescale 1ns/10ps
`default_nettype none
module tdr_line_sync
    import tdr_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // bus lines
    input wire logic scl_in,
    input wire logic sda_in,
    // events
    output tdr_line_ev_t ev
);
    logic [1:0] scl_sync_r, scl_sync_nxt;
    logic [1:0] sda_sync_r, sda_sync_nxt;
    logic scl_d_r, scl_d_nxt;
    logic sda_d_r, sda_d_nxt;

    always_comb begin
        scl_sync_nxt = {scl_sync_r[0], scl_in};
        sda_sync_nxt = {sda_sync_r[0], sda_in};
        scl_d_nxt = scl_sync_r[1];
        sda_d_nxt = sda_sync_r[1];
    end

    // idle bus is high, so reset to one to avoid a false start
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_sync_r <= scl_sync_nxt;
            sda_sync_r <= sda_sync_nxt;
            scl_d_r <= scl_d_nxt;
            sda_d_r <= sda_d_nxt;
        end
    end

    // only the second stage and its delayed copy are looked at
    always_comb begin
        ev.scl_rise = scl_sync_r[1] & ~scl_d_r;
        ev.scl_fall = ~scl_sync_r[1] & scl_d_r;
        ev.start = scl_sync_r[1] & scl_d_r & sda_d_r & ~sda_sync_r[1];
        ev.stop = scl_sync_r[1] & scl_d_r & ~sda_d_r & sda_sync_r[1];
        ev.sda = sda_sync_r[1];
    end
endmodule : tdr_line_sync
`default_nettype wire

// ### tdr_power_seq.sv
// sequences power-down entry and exit within the allowed times
`timescale 1ns/10ps
`default_nettype none
`include "tdr_params.svh"
module tdr_power_seq
    import tdr_pkg::*;
#(
    parameter int ENTRY_CYC = `TDR_PD_ENTRY_CYC,
    parameter int EXIT_CYC = `TDR_PD_EXIT_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // requested mode
    input wire logic power_down_req,
    // analog controls
    output logic core_enable,
    output logic out_ground,
    output logic power_ready
);
    localparam int CW = $clog2(EXIT_CYC + 1);
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic pd_r, pd_nxt;

    always_comb begin
        pd_nxt = pd_r;
        cnt_nxt = cnt_r;
        if (power_down_req != pd_r) begin
            pd_nxt = power_down_req;
            cnt_nxt = power_down_req ? CW'(ENTRY_CYC) : CW'(EXIT_CYC);
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - CW'(1);
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pd_r <= 1'b0;
            cnt_r <= '0;
        end else begin
            pd_r <= pd_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // ground switch closes at once; ready marks the settle window is over
    assign core_enable = ~pd_r;
    assign out_ground = pd_r;
    assign power_ready = (cnt_r == '0);
endmodule : tdr_power_seq
`default_nettype wire

// ### tdr_dac_receiver.sv
// receive-only two-wire target holding a dac code and power mode
`timescale 1ns/10ps
`default_nettype none
`include "tdr_params.svh"
module tdr_dac_receiver
    import tdr_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = `TDR_ADDR_DEFAULT,
    parameter int ENTRY_CYC = `TDR_PD_ENTRY_CYC,
    parameter int EXIT_CYC = `TDR_PD_EXIT_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // two-wire bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // dac side
    output logic [7:0] dac_code,
    output logic [5:0] dac_code_msb,
    output logic power_down_bit,
    output logic core_enable,
    output logic out_ground,
    output logic power_ready,
    output logic update_pulse
);
    tdr_line_ev_t ev;
    tdr_state_t state_r, state_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [3:0] bitcnt_r, bitcnt_nxt;
    logic pd_req_r, pd_req_nxt;
    logic ack_r, ack_nxt;
    tdr_update_t pend_r, pend_nxt;
    tdr_update_t held_r, held_nxt;
    logic upd_r, upd_nxt;
    logic addr_hit;

    tdr_line_sync u_sync (
        .core_clk(core_clk),
        .resetn(resetn),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .ev(ev)
    );

    // 25 MHz oversamples a 400 kHz scl about 62 times per period

    // general call (all zero) and ten-bit prefixes never equal a legal preset
    always_comb begin
        addr_hit = (shift_r[7:1] == DEV_ADDR)
            && (shift_r[7:1] != `TDR_GEN_CALL)
            && (shift_r[7:3] != `TDR_TEN_BIT_PFX);
    end

    always_comb begin
        state_nxt = state_r;
        shift_nxt = shift_r;
        bitcnt_nxt = bitcnt_r;
        pd_req_nxt = pd_req_r;
        ack_nxt = ack_r;
        pend_nxt = pend_r;
        held_nxt = held_r;
        upd_nxt = 1'b0;
        if (ev.start) begin
            // a restart abandons any unfinished or un-stopped transfer
            state_nxt = TDR_ADDR;
            bitcnt_nxt = 4'h0;
            ack_nxt = 1'b0;
        end else if (ev.stop) begin
            if (state_r == TDR_WAIT_STOP) begin
                held_nxt = pend_r;
                upd_nxt = 1'b1;
            end
            state_nxt = TDR_IDLE;
            ack_nxt = 1'b0;
        end else begin
            case (state_r)
                TDR_IDLE: begin
                    ack_nxt = 1'b0;
                end
                TDR_ADDR, TDR_DATA: begin
                    if (ev.scl_rise) begin
                        shift_nxt = {shift_r[6:0], ev.sda};
                        bitcnt_nxt = bitcnt_r + 4'h1;
                    end else if (ev.scl_fall && bitcnt_r == `TDR_BITS_PER_BYTE) begin
                        bitcnt_nxt = 4'h0;
                        if (state_r == TDR_DATA) begin
                            // in power-down the data byte is dropped and the held code kept; the byte is still acked on sda
                            pend_nxt.code = pd_req_r ? held_r.code : shift_r;
                            pend_nxt.power_down_bit = pd_req_r;
                            ack_nxt = 1'b1;
                            state_nxt = TDR_DATA_ACK;
                        end else if (addr_hit) begin
                            pd_req_nxt = shift_r[0];
                            ack_nxt = 1'b1;
                            state_nxt = TDR_ADDR_ACK;
                        end else begin
                            state_nxt = TDR_IDLE;
                        end
                    end
                end
                TDR_ADDR_ACK: begin
                    if (ev.scl_fall) begin
                        ack_nxt = 1'b0;
                        state_nxt = TDR_DATA;
                    end
                end
                TDR_DATA_ACK: begin
                    if (ev.scl_fall) begin
                        ack_nxt = 1'b0;
                        state_nxt = TDR_WAIT_STOP;
                    end
                end
                TDR_WAIT_STOP: begin
                    // further clocks are ignored until stop or restart
                    ack_nxt = 1'b0;
                end
                default: begin
                    state_nxt = TDR_IDLE;
                    ack_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= TDR_IDLE;
            shift_r <= 8'h00;
            bitcnt_r <= 4'h0;
            pd_req_r <= 1'b0;
            ack_r <= 1'b0;
            pend_r <= '0;
            held_r <= {1'b0, `TDR_CODE_RESET};
            upd_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            shift_r <= shift_nxt;
            bitcnt_r <= bitcnt_nxt;
            pd_req_r <= pd_req_nxt;
            ack_r <= ack_nxt;
            pend_r <= pend_nxt;
            held_r <= held_nxt;
            upd_r <= upd_nxt;
        end
    end

    tdr_power_seq #(
        .ENTRY_CYC(ENTRY_CYC),
        .EXIT_CYC(EXIT_CYC)
    ) u_pwr (
        .core_clk(core_clk),
        .resetn(resetn),
        .power_down_req(held_r.power_down_bit),
        .core_enable(core_enable),
        .out_ground(out_ground),
        .power_ready(power_ready)
    );

    // open drain: only a low is ever driven
    assign sda_out = 1'b0;
    assign sda_oe = ack_r;
    assign dac_code = held_r.code;
    assign dac_code_msb = held_r.code[7:2];
    assign power_down_bit = held_r.power_down_bit;
    assign update_pulse = upd_r;
endmodule : tdr_dac_receiver
`default_nettype wire

// ### tdr_dac_receiver_checker.sv
// port assertions for the two-wire dac code receiver
`timescale 1ns/10ps
`default_nettype none
module tdr_dac_receiver_checker
    import tdr_pkg::*;
#(
    parameter int ENTRY_CYC = 4,
    parameter int EXIT_CYC = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // two-wire bus
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // dac side
    input wire logic [7:0] dac_code,
    input wire logic [5:0] dac_code_msb,
    input wire logic power_down_bit,
    input wire logic core_enable,
    input wire logic out_ground,
    input wire logic power_ready,
    input wire logic update_pulse
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // counts the settle window; slack covers the sync stages
    logic [15:0] low_cnt_r;
    logic [15:0] low_cnt_nxt;
    always_comb low_cnt_nxt = power_ready ? 16'h0000 : low_cnt_r + 16'h0001;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) low_cnt_r <= 16'h0000;
        else low_cnt_r <= low_cnt_nxt;
    end
    AST_SDA_ONLY_LOW: assert property (sda_out == 1'b0) else $error("sda high");
    AST_MSB_SLICE: assert property (dac_code_msb == dac_code[7:2]) else $error("msb");
    AST_GND_OPP: assert property (out_ground != core_enable) else $error("gnd en");
    AST_GND_PD: assert property ($stable(power_down_bit) [*2] |->
        out_ground == power_down_bit) else $error("gnd");
    AST_LOAD_ON_STOP: assert property ($changed({dac_code, power_down_bit}) |->
        update_pulse || $past(update_pulse)) else $error("load");
    AST_PULSE_ONE: assert property (update_pulse |=> !update_pulse) else $error("pulse");
    AST_ACK_RISE: assert property ($rose(sda_oe) |-> !scl_in) else $error("ack rise");
    AST_ACK_FALL: assert property ($fell(sda_oe) |-> !scl_in) else $error("ack fall");
    AST_ACK_LEN: assert property ($rose(sda_oe) |-> sda_oe [*6]) else $error("ack len");
    AST_READY_DROP: assert property ($changed(power_down_bit) |-> ##[0:2] !power_ready)
        else $error("ready");
    AST_READY_BOUND: assert property (low_cnt_r <= ENTRY_CYC + EXIT_CYC + 4)
        else $error("settle");
    cover property (update_pulse && power_down_bit);
    cover property (update_pulse && !power_down_bit);
    cover property ($rose(sda_oe));
endmodule : tdr_dac_receiver_checker
bind tdr_dac_receiver tdr_dac_receiver_checker #(.ENTRY_CYC(ENTRY_CYC), .EXIT_CYC(EXIT_CYC))
    chk (.core_clk, .resetn, .scl_in, .sda_in, .sda_out, .sda_oe, .dac_code, .dac_code_msb,
    .power_down_bit, .core_enable, .out_ground, .power_ready, .update_pulse);
`default_nettype wire

// ### tdr_bus_master.sv
// behavioural two-wire bus master for the dac code receiver
`timescale 1ns/10ps
`default_nettype none
module tdr_bus_master
    import tdr_pkg::*;
(
    // pacing clock
    input wire logic core_clk,
    // resolved data line, pulled up when released
    input wire logic sda,
    // driven lines
    output logic scl,
    output logic sda_m
);
    // scl stands still high between frames
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : w
    // 8 core cycles per bit; faster than a real bus to keep runs short
    task automatic bit_io(input logic b, output logic s);
        scl = 1'b0;
        w(2);
        sda_m = b;
        w(2);
        scl = 1'b1;
        w(2);
        s = sda;
        w(2);
    endtask : bit_io
    task automatic start();
        if (!sda) begin
            bit_io(1'b1, sda_m);
            sda_m = 1'b1;
        end
        sda_m = 1'b0;
        w(2);
    endtask : start
    task automatic stop();
        scl = 1'b0;
        w(2);
        sda_m = 1'b0;
        w(2);
        scl = 1'b1;
        w(2);
        sda_m = 1'b1;
        w(4);
    endtask : stop
    task automatic byte_io(input logic [7:0] d, output logic ack, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(1'b1, ack);
    endtask : byte_io
endmodule : tdr_bus_master
`default_nettype wire

// ### tdr_dac_receiver_tb_top.sv
// self-checking bench for the two-wire dac code receiver
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tdr_dac_receiver_tb_top;
    import tdr_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    int n_mismatch = 0;
    int checks = 0;
    // the wires up to dac_code_msb are driven by an instance, so they are nets, not bench variables
    wire scl_in, sda_m, sda_oe, sda_out, power_down_bit, core_enable, out_ground;
    wire power_ready, update_pulse;
    wire [7:0] dac_code;
    wire [5:0] dac_code_msb;
    logic aa, da;
    logic [7:0] q;
    wire sda_in;
    // open drain: the pull-up wins unless someone pulls low
    assign sda_in = sda_m & ~(sda_oe & ~sda_out);
    tdr_bus_master m (.core_clk(core_clk), .sda(sda_in), .scl(scl_in), .sda_m(sda_m));
    tdr_dac_receiver #(.DEV_ADDR(7'h30), .ENTRY_CYC(4), .EXIT_CYC(8)) dut (.core_clk,
        .resetn, .scl_in, .sda_in, .sda_out, .sda_oe, .dac_code, .dac_code_msb,
        .power_down_bit, .core_enable, .out_ground, .power_ready, .update_pulse);
    always #20 core_clk = ~core_clk;
    task automatic end_of_test();
        if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test
    task automatic frame(input logic [7:0] a, input logic [7:0] d);
        m.start();
        m.byte_io(a, aa, q);
        m.byte_io(d, da, q);
    endtask : frame
    task automatic t_reset();
        `CHK(dac_code, 8'h00)
        `CHK({power_down_bit, core_enable, power_ready, sda_oe}, 4'h6)
    endtask : t_reset
    task automatic t_write();
        frame(8'h60, 8'ha7);
        m.stop();
        m.w(6);
        `CHK(aa, 1'b0)
        `CHK(da, 1'b0)
        `CHK(dac_code, 8'ha7)
        `CHK(dac_code_msb, 6'h29)
        `CHK(power_down_bit, 1'b0)
        `CHK(update_pulse, 1'b0)
    endtask : t_write
    task automatic t_refuse();
        logic [7:0] bad [3] = '{8'h62, 8'h00, 8'hf0};
        foreach (bad[i]) begin
            frame(bad[i], 8'h10);
            m.stop();
            m.w(6);
            `CHK(aa, 1'b1)
            `CHK(dac_code, 8'ha7)
        end
    endtask : t_refuse
    task automatic t_abort();
        m.start();
        m.byte_io(8'h61, aa, q);
        m.stop();
        m.w(6);
        `CHK(aa, 1'b0)
        `CHK(power_down_bit, 1'b0)
        frame(8'h60, 8'h3c);
        m.start();
        m.byte_io(8'h61, aa, q);
        m.stop();
        m.w(6);
        `CHK(dac_code, 8'ha7)
        `CHK(power_down_bit, 1'b0)
    endtask : t_abort
    task automatic t_power();
        frame(8'h61, 8'hff);
        m.stop();
        m.w(6);
        `CHK(q, 8'hff)
        `CHK(da, 1'b0)
        `CHK(power_down_bit, 1'b1)
        `CHK(out_ground, 1'b1)
        `CHK(dac_code, 8'ha7)
        m.w(20);
        `CHK(power_ready, 1'b1)
        frame(8'h60, 8'h00);
        m.stop();
        m.w(20);
        `CHK(core_enable, 1'b1)
        `CHK(dac_code, 8'h00)
        `CHK(power_ready, 1'b1)
    endtask : t_power
    initial begin
        repeat (10) @(posedge core_clk);
        #1;
        resetn = 1'b1;
        m.w(2);
        t_reset();
        t_write();
        t_refuse();
        t_abort();
        t_power();
        end_of_test();
    end
    // a hang is cut after nearly four times the expected run
    initial begin
        #200000;
        n_mismatch++;
        end_of_test();
    end
endmodule : tdr_dac_receiver_tb_top
`default_nettype wire
